// ===== src/batt_alarm_params.svh
`ifndef BATT_ALARM_PARAMS_SVH
`define BATT_ALARM_PARAMS_SVH
// How it works
// - Strap selects alarm or warning; read once
// - Low battery comparator raises alarm or warning
// - Alarm output at start, then 4 s check
// - Alarm mode ignores low battery after window
// - Warning mode checks battery continuously after start
// - Battery alarm cleared only by power cycle
// - Fault bit one while alarm active
// - Error code holds the active alarm code
// - Emergency message sent on each alarm raised while none active
// - Panel shows code one character at once
// - Reset clears resettable alarms whose cause left

// ****************************************
// Timing
// ****************************************
`define CLK_KHZ          25000
`define STARTUP_MS       5000
`define WINDOW_MS        4000
`define PANEL_MS         500
`define TMR_W            27

// ****************************************
// Codes
// ****************************************
`define CODE_BATT_ALARM  12'h830
`define CODE_BATT_WARN   12'h930
`define FAULT_BIT        3

// ****************************************
// Register map
// ****************************************
`define OFS_CTRL         8'h00
`define OFS_STATUSWORD   8'h04
`define OFS_ERROR_CODE   8'h08
`define OFS_WARN_CODE    8'h0c
`define OFS_IRQ_STATUS   8'h10
`define OFS_IRQ_MASK     8'h14
`define OFS_INFO         8'h18
`define CTRL_RESET_BIT   0
`define IRQ_ALARM_BIT    0
`define IRQ_WARN_BIT     1
`define IRQ_CLEAR_BIT    2
`define IRQ_W            3
`endif

// ===== src/batt_alarm_pkg.sv
package batt_alarm_pkg;
    typedef enum logic [1:0] {
        PH_START  = 2'b00,
        PH_WINDOW = 2'b01,
        PH_RUN    = 2'b11
    } phase_t;

    typedef struct packed {
        logic [11:0] code;
        logic        nores;
    } alarm_t;
endpackage : batt_alarm_pkg

// ===== src/battery_monitor_alarm_report.sv
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "batt_alarm_params.svh"
module battery_monitor_alarm_report
    import batt_alarm_pkg::*;
#(
    parameter int STARTUP_CYC = `STARTUP_MS * `CLK_KHZ,
    parameter int WINDOW_CYC  = `WINDOW_MS * `CLK_KHZ,
    parameter int PANEL_CYC   = `PANEL_MS * `CLK_KHZ
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        battery_low_pin,
    input  wire logic        battery_report_select,
    input  wire logic        ext_alarm_set,
    input  wire alarm_t      ext_alarm,
    input  wire logic        ext_alarm_cause,
    input  wire logic        alarm_reset_req,
    output logic             servo_alarm_output,
    output logic [15:0]      statusword,
    output logic [15:0]      error_code,
    output logic             emcy_valid,
    input  wire logic        emcy_ready,
    output alarm_t           emcy_msg,
    output logic [7:0]       panel_char,
    output logic             irq
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] low_sync_r;
    logic [1:0] sel_sync_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_sync_r <= 2'b00;
            sel_sync_r <= 2'b00;
        end else begin
            low_sync_r <= {low_sync_r[0], battery_low_pin};
            sel_sync_r <= {sel_sync_r[0], battery_report_select};
        end
    end
    wire batt_low = low_sync_r[1];

    // ****************************************
    // Power-on phases
    // ****************************************
    phase_t             phase_r;
    logic [`TMR_W-1:0]  tmr_r;
    logic               sel_act_r;
    wire start_end  = (phase_r == PH_START) &&
                      (tmr_r == `TMR_W'(STARTUP_CYC - 1));
    wire window_end = (phase_r == PH_WINDOW) &&
                      (tmr_r == `TMR_W'(WINDOW_CYC - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= PH_START;
            tmr_r   <= '0;
        end else if (start_end) begin
            phase_r <= PH_WINDOW;
            tmr_r   <= '0;
        end else if (window_end) begin
            phase_r <= PH_RUN;
            tmr_r   <= '0;
        end else if (phase_r != PH_RUN) begin
            tmr_r   <= tmr_r + `TMR_W'(1);
        end
    end

    // Selection sampled once, long after the synchroniser settled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_act_r <= 1'b0;
        end else if (start_end) begin
            sel_act_r <= sel_sync_r[1];
        end
    end
    wire warn_mode = sel_act_r;

    // ****************************************
    // Battery checks
    // ****************************************
    wire batt_alarm_hit = !warn_mode && batt_low &&
                          (phase_r == PH_WINDOW);
    wire batt_warn_nxt  = warn_mode && batt_low &&
                          (phase_r != PH_START);
    logic batt_warn_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) batt_warn_r <= 1'b0;
        else          batt_warn_r <= batt_warn_nxt;
    end

    // ****************************************
    // Active alarm
    // ****************************************
    logic   alarm_act_r;
    alarm_t alarm_r;
    logic   sw_reset;
    wire    batt_new    = batt_alarm_hit && !alarm_act_r;
    wire    ext_new     = ext_alarm_set && !alarm_act_r && !batt_alarm_hit;
    wire    alarm_new   = batt_new || ext_new;
    wire    rst_req     = alarm_reset_req || sw_reset;
    wire    alarm_clear = rst_req && alarm_act_r && !alarm_r.nores &&
                          !ext_alarm_cause;
    wire    cause_again = ext_alarm_set || batt_alarm_hit;
    wire    do_clear    = alarm_clear && !cause_again;
    alarm_t batt_entry;
    assign batt_entry = {`CODE_BATT_ALARM, 1'b1};

    // First alarm holds its code until cleared; set beats clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_act_r <= 1'b0;
            alarm_r     <= '0;
        end else if (alarm_new) begin
            alarm_act_r <= 1'b1;
            alarm_r     <= batt_new ? batt_entry : ext_alarm;
        end else if (do_clear) begin
            alarm_act_r <= 1'b0;
            alarm_r     <= '0;
        end
    end

    // ****************************************
    // Emergency message
    // ****************************************
    logic emcy_valid_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            emcy_valid_r <= 1'b0;
            emcy_msg     <= '0;
        end else if (alarm_new) begin
            emcy_valid_r <= 1'b1;
            emcy_msg     <= batt_new ? batt_entry : ext_alarm;
        end else if (emcy_ready) begin
            emcy_valid_r <= 1'b0;
        end
    end
    assign emcy_valid = emcy_valid_r;

    // ****************************************
    // Panel display
    // ****************************************
    logic [`TMR_W-1:0] pan_tmr_r;
    logic [2:0]        pan_idx_r;
    wire pan_tick = (pan_tmr_r == `TMR_W'(PANEL_CYC - 1));
    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'ha) ? 8'h30 + {4'h0, n}
                              : 8'h57 + {4'h0, n};
    endfunction : hex_char
    logic [7:0] pan_sel;
    always_comb begin
        unique case (pan_idx_r)
            3'd0:    pan_sel = 8'h41;
            3'd1:    pan_sel = 8'h2e;
            3'd2:    pan_sel = hex_char(alarm_r.code[11:8]);
            3'd3:    pan_sel = hex_char(alarm_r.code[7:4]);
            3'd4:    pan_sel = hex_char(alarm_r.code[3:0]);
            default: pan_sel = 8'h20;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pan_tmr_r  <= '0;
            pan_idx_r  <= '0;
            panel_char <= 8'h20;
        end else if (!alarm_act_r) begin
            pan_tmr_r  <= '0;
            pan_idx_r  <= '0;
            panel_char <= 8'h20;
        end else begin
            panel_char <= pan_sel;
            pan_tmr_r  <= pan_tick ? '0 : pan_tmr_r + `TMR_W'(1);
            if (pan_tick)
                pan_idx_r <= (pan_idx_r == 3'd5) ? 3'd0
                                                 : pan_idx_r + 3'd1;
        end
    end

    // ****************************************
    // Status outputs
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            servo_alarm_output <= 1'b1;
            statusword         <= '0;
            error_code         <= '0;
        end else begin
            servo_alarm_output <= (phase_r == PH_START) ||
                                  alarm_act_r;
            statusword         <= 16'(alarm_act_r) << `FAULT_BIT;
            error_code         <= {4'h0, alarm_r.code};
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    logic       wr_pend_r;
    logic [7:0] wr_ofs_r;
    logic [`IRQ_W-1:0] irq_st_r;
    logic [`IRQ_W-1:0] irq_mask_r;
    wire acc    = hsel && hready && htrans[1];
    wire rd_acc = acc && !hwrite;
    wire wr_data = wr_pend_r;
    assign sw_reset = wr_data && (wr_ofs_r == `OFS_CTRL) &&
                      hwdata[`CTRL_RESET_BIT];
    wire irq_w1c = wr_data && (wr_ofs_r == `OFS_IRQ_STATUS);
    wire [`IRQ_W-1:0] irq_ev = {do_clear, batt_warn_nxt && !batt_warn_r,
                                alarm_new};
    wire [`IRQ_W-1:0] irq_st_nxt =
        irq_ev | (irq_st_r & ~(irq_w1c ? hwdata[`IRQ_W-1:0] : '0));
    wire [7:0] rd_ofs = haddr[7:0];
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (haddr[31:8] == 24'h0) begin
            unique case (rd_ofs)
                `OFS_STATUSWORD: rd_mux = {16'h0, statusword};
                `OFS_ERROR_CODE: rd_mux = {16'h0, error_code};
                `OFS_WARN_CODE:  rd_mux = batt_warn_r ?
                                          {20'h0, `CODE_BATT_WARN} : 32'h0;
                `OFS_IRQ_STATUS: rd_mux = {29'h0, irq_st_r};
                `OFS_IRQ_MASK:   rd_mux = {29'h0, irq_mask_r};
                `OFS_INFO:       rd_mux = {28'h0, batt_low, phase_r,
                                           sel_act_r};
                default:         rd_mux = 32'h0;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r  <= '0;
            hrdata    <= '0;
        end else begin
            wr_pend_r <= acc && hwrite && (haddr[31:8] == 24'h0);
            wr_ofs_r  <= haddr[7:0];
            if (rd_acc) hrdata <= rd_mux;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_r   <= '0;
            irq_mask_r <= '0;
        end else begin
            irq_st_r <= irq_st_nxt;
            if (wr_data && (wr_ofs_r == `OFS_IRQ_MASK))
                irq_mask_r <= hwdata[`IRQ_W-1:0];
        end
    end
    assign irq       = |(irq_st_r & irq_mask_r);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_window_low;
        (phase_r == PH_WINDOW) && !warn_mode && batt_low && !alarm_act_r;
    endsequence
    sequence s_alarm_up;
        alarm_act_r && (alarm_r.code == `CODE_BATT_ALARM) ##1 statusword[3];
    endsequence

    batt_alarm_raise_a: assert property (s_window_low |=> s_alarm_up)
        else $error("battery alarm not raised in window");
    no_late_alarm_a: assert property ((phase_r == PH_RUN) &&
        !warn_mode && !alarm_act_r && !ext_alarm_set |=> !alarm_act_r)
        else $error("battery alarm raised after window");
    start_output_a: assert property ((phase_r == PH_START) |=>
        servo_alarm_output)
        else $error("alarm output low in start phase");
    warn_follow_a: assert property (warn_mode && (phase_r == PH_RUN)
        |=> batt_warn_r == $past(batt_low))
        else $error("warning does not follow battery");
    batt_hold_a: assert property (alarm_act_r && alarm_r.nores |=>
        alarm_act_r && $stable(alarm_r))
        else $error("battery alarm cleared");
    fault_bit_a: assert property (statusword[3] == $past(alarm_act_r))
        else $error("fault bit wrong");
    code_hold_a: assert property (alarm_act_r && !do_clear |=>
        $stable(alarm_r.code) ##1 error_code[11:0] == $past(alarm_r.code))
        else $error("error code changed");
    emcy_send_a: assert property (alarm_new ||
        (emcy_valid && !emcy_ready) |=> emcy_valid)
        else $error("emergency not held");
    emcy_bound_a: assert property (emcy_valid && emcy_ready &&
        !alarm_new |=> !emcy_valid)
        else $error("emergency not released");
    panel_first_a: assert property ($rose(alarm_act_r) |=>
        panel_char == 8'h41)
        else $error("panel does not start with letter");
    reset_clear_a: assert property (alarm_clear && !cause_again
        |=> !alarm_act_r ##1 !statusword[3])
        else $error("resettable alarm not cleared");
endmodule : battery_monitor_alarm_report

// ===== verification/emcy_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host side of the emergency channel
// ****************************************
// Alternates a prompt accept with a three-cycle stall so the sender
// must hold its message through a wait.
module emcy_host_model
    import batt_alarm_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic emcy_valid,
    input  wire alarm_t emcy_msg,
    output logic      emcy_ready,
    output int        rx_cnt,
    output alarm_t    rx_msg
);
    logic slow;
    int   wait_cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            emcy_ready <= 1'b0;
            rx_cnt     <= 0;
            rx_msg     <= '0;
            slow       <= 1'b0;
            wait_cnt   <= 0;
        end else if (emcy_valid && emcy_ready) begin
            emcy_ready <= 1'b0;
            rx_cnt     <= rx_cnt + 1;
            rx_msg     <= emcy_msg;
            slow       <= !slow;
            wait_cnt   <= 0;
        end else if (emcy_valid) begin
            wait_cnt   <= wait_cnt + 1;
            emcy_ready <= (wait_cnt >= (slow ? 3 : 0));
        end
    end
endmodule : emcy_host_model

// ===== verification/battery_monitor_alarm_report_test.sv
`timescale 1ns/1ps
`include "batt_alarm_params.svh"
module battery_monitor_alarm_report_test
    import batt_alarm_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        batt_low, sel, ext_set, ext_cause, rst_req, emcy_valid;
    logic        emcy_ready, servo_alarm_output;
    alarm_t      ext_info, emcy_msg, rx_msg;
    logic [15:0] statusword, error_code;
    logic [7:0]  panel_char;
    int          rx_cnt, error_cnt, cmp_count;

    // Short phase counts keep the run brief; expectations follow them
    battery_monitor_alarm_report #(
        .STARTUP_CYC(50), .WINDOW_CYC(40), .PANEL_CYC(4)
    ) battery_monitor_alarm_report_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .battery_low_pin(batt_low),
        .battery_report_select(sel), .ext_alarm_set(ext_set),
        .ext_alarm(ext_info), .ext_alarm_cause(ext_cause),
        .alarm_reset_req(rst_req), .servo_alarm_output(servo_alarm_output),
        .statusword(statusword), .error_code(error_code),
        .emcy_valid(emcy_valid), .emcy_ready(emcy_ready),
        .emcy_msg(emcy_msg), .panel_char(panel_char), .irq(irq)
    );
    emcy_host_model emcy_host_model_inst (
        .hclk(hclk), .hresetn(hresetn), .emcy_valid(emcy_valid),
        .emcy_msg(emcy_msg), .emcy_ready(emcy_ready), .rx_cnt(rx_cnt),
        .rx_msg(rx_msg)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // Control power cycle; the strap is only read after this
    task power_on(input logic s, input logic low);
        @(posedge hclk);
        hresetn  <= 1'b0;
        sel      <= s;
        batt_low <= low;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
    endtask : power_on

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdat = hrdata;
        @(negedge hclk);
    endtask : ahb

    task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(n, rdat, e);
        chk("hresp", hresp, 1'b0);
    endtask : rd_chk

    task wait_fault(input logic v);
        for (int i = 0; i < 200 && statusword[3] !== v; i++)
            @(negedge hclk);
    endtask : wait_fault

    task pulse_ext(input logic [11:0] c, input logic nr);
        @(posedge hclk);
        ext_set  <= 1'b1;
        ext_info <= {c, nr};
        @(posedge hclk);
        ext_set <= 1'b0;
    endtask : pulse_ext

    task pulse_rst;
        @(posedge hclk);
        rst_req <= 1'b1;
        @(posedge hclk);
        rst_req <= 1'b0;
        repeat (6) @(negedge hclk);
    endtask : pulse_rst

    task set_low(input logic v);
        @(posedge hclk);
        batt_low <= v;
        repeat (12) @(negedge hclk);
    endtask : set_low

    // ****************************************
    // Scenarios
    // ****************************************
    task t_alarm_mode;
        string s;
        s = "A.830 ";
        power_on(1'b0, 1'b1);
        chk("out_start", servo_alarm_output, 1'b1);
        chk("sw_start", statusword, 16'h0000);
        ahb(1'b1, `OFS_IRQ_MASK, 32'h1);
        wait_fault(1'b1);
        chk("sw", statusword, 16'h0008);
        chk("code", error_code, 16'h0830);
        chk("irq_on", irq, 1'b1);
        rd_chk("sw_reg", `OFS_STATUSWORD, 32'h8);
        for (int i = 0; i < 20 && rx_cnt != 1; i++) @(negedge hclk);
        chk("emcy", rx_msg, {12'h830, 1'b1});
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < (k == 0 ? 30 : 5) && panel_char !== s[k]; i++)
                @(negedge hclk);
            chk("panel", panel_char, s[k]);
        end
        set_low(1'b0);
        ahb(1'b1, `OFS_CTRL, 32'h1);
        pulse_rst();
        chk("kept", statusword[3], 1'b1);
        chk("code_kept", error_code, 16'h0830);
        ahb(1'b1, `OFS_IRQ_MASK, 32'h0);
        chk("irq_off", irq, 1'b0);
        rd_chk("irq_st", `OFS_IRQ_STATUS, 32'h1);
        ahb(1'b1, `OFS_IRQ_STATUS, 32'h1);
        rd_chk("irq_clr", `OFS_IRQ_STATUS, 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        power_on(1'b0, 1'b0);
        chk("cycled", statusword, 16'h0000);
        chk("cycled_code", error_code, 16'h0000);
        $display("alarm mode test done");
    endtask : t_alarm_mode

    task t_after_window;
        power_on(1'b0, 1'b0);
        repeat (100) @(negedge hclk);
        rd_chk("info", `OFS_INFO, 32'h6);
        // Strap moved while powered: must not act before a restart
        @(posedge hclk);
        sel <= 1'b1;
        set_low(1'b1);
        rd_chk("sel_latched", `OFS_WARN_CODE, 32'h0);
        chk("late_low", statusword, 16'h0000);
        chk("late_out", servo_alarm_output, 1'b0);
        $display("window end test done");
    endtask : t_after_window

    task t_warn_mode;
        power_on(1'b1, 1'b0);
        chk("out_start", servo_alarm_output, 1'b1);
        repeat (100) @(negedge hclk);
        set_low(1'b1);
        rd_chk("warn", `OFS_WARN_CODE, 32'h930);
        chk("no_fault", statusword, 16'h0000);
        chk("no_out", servo_alarm_output, 1'b0);
        rd_chk("irq_st", `OFS_IRQ_STATUS, 32'h2);
        set_low(1'b0);
        rd_chk("warn_gone", `OFS_WARN_CODE, 32'h0);
        $display("warning mode test done");
    endtask : t_warn_mode

    task t_ext_alarm;
        power_on(1'b0, 1'b0);
        repeat (100) @(negedge hclk);
        @(posedge hclk);
        ext_cause <= 1'b1;
        pulse_ext(12'h100, 1'b0);
        wait_fault(1'b1);
        chk("ext_code", error_code, 16'h0100);
        pulse_ext(12'h101, 1'b0);
        repeat (5) @(negedge hclk);
        chk("first_held", error_code, 16'h0100);
        pulse_rst();
        chk("cause_on", statusword[3], 1'b1);
        @(posedge hclk);
        ext_cause <= 1'b0;
        ahb(1'b1, `OFS_CTRL, 32'h1);
        wait_fault(1'b0);
        chk("reset_ok", statusword, 16'h0000);
        chk("code_clr", error_code, 16'h0000);
        rd_chk("irq_st", `OFS_IRQ_STATUS, 32'h5);
        pulse_ext(12'h020, 1'b1);
        wait_fault(1'b1);
        pulse_rst();
        chk("nores", statusword[3], 1'b1);
        chk("emcy_cnt", rx_cnt, 32'd2);
        chk("emcy_last", rx_msg, {12'h020, 1'b1});
        $display("external alarm test done");
    endtask : t_ext_alarm

    // ****************************************
    // Run
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial begin
        #(40 * 5000);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        {hresetn, hsel, hwrite, batt_low, sel} = '0;
        {ext_set, ext_cause, rst_req} = '0;
        haddr = '0;
        hwdata = '0;
        htrans = 2'b00;
        hsize = 3'b010;
        ext_info = '0;
        error_cnt = 0;
        cmp_count = 0;
        t_alarm_mode();
        t_after_window();
        t_warn_mode();
        t_ext_alarm();
        tally_and_finish();
    end
endmodule : battery_monitor_alarm_report_test
